// [dual_reload_pwm_timer.sv]
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module dual_reload_pwm_timer
   import dual_reload_pwm_timer_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // apb slave
   input apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pins
   input wire logic shutdown_n,
   output logic [3:0] modulated_output,
   output logic compare_request
);
   timer_state_t s_reg;
   timer_state_t s_next;
   logic mapped;

   // address decode
   always_comb begin
      mapped = 1'b0;
      case (apb_req.paddr)
         OFS_CTRL, OFS_RELOAD_ONE, OFS_RELOAD_TWO, OFS_OUT_CTRL, OFS_DEAD_TIME,
         OFS_SHUTDOWN, OFS_COUNT_ONE, OFS_COUNT_TWO, OFS_PORT: begin
            mapped = 1'b1;
         end
         default: begin
            for (int i = 0; i < CH_N; i++) begin
               if (apb_req.paddr == OFS_CSR0 + 8'(i * 4)) begin
                  mapped = 1'b1;
               end
               if (apb_req.paddr == OFS_DUTY0 + 8'(i * 4)) begin
                  mapped = 1'b1;
               end
            end
         end
      endcase
   end

   assign pready = 1'b1;
   assign pslverr = apb_req.psel & apb_req.penable & ~mapped;
   assign prdata = s_reg.prdata;
   assign modulated_output = s_reg.pins;
   assign compare_request = s_reg.cmp_req;

   always_comb begin
      logic ovf1;
      logic ovf2;
      logic wr_acc;
      logic rd_setup;
      logic rd_acc;
      logic dt_on;
      logic [3:0] ch_ovf;
      logic [3:0] ch_tran;
      logic [3:0] cmp_hit;
      logic [3:0] clr;
      logic [3:0] wave;
      logic [31:0] rdata;
      logic [CH_N-1:0][CNT_W-1:0] ch_cnt;
      s_next = s_reg;
      ovf1 = 1'b0;
      ovf2 = 1'b0;
      ch_ovf = 4'h0;
      ch_tran = 4'h0;
      cmp_hit = 4'h0;
      clr = 4'h0;
      wave = 4'h0;
      rdata = 32'h0000_0000;
      ch_cnt = '0;
      dt_on = 1'b0;
      wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite & mapped;
      rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite & mapped;
      rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

      // counters
      ovf1 = (s_reg.cnt1 == CNT_MAX) && !s_reg.brk_act;
      ovf2 = (s_reg.cnt2 == CNT_MAX) && !s_reg.brk_act;
      s_next.cnt1 = ovf1 ? s_reg.rld1 : s_reg.cnt1 + 12'h001;
      s_next.cnt2 = ovf2 ? s_reg.rld2 : s_reg.cnt2 + 12'h001;

      // channel to counter mapping
      for (int i = 0; i < CH_N; i++) begin
         if (s_reg.dual && i >= 2) begin
            ch_cnt[i] = s_reg.cnt2;
            ch_ovf[i] = ovf2;
            ch_tran[i] = s_reg.transfer_bit_two;
         end else begin
            ch_cnt[i] = s_reg.cnt1;
            ch_ovf[i] = ovf1;
            ch_tran[i] = s_reg.transfer_bit_one;
         end
         if (ch_ovf[i] && ch_tran[i]) begin
            s_next.duty_act[i] = s_reg.duty_pre[i];
         end
         if (!ch_tran[i] || ch_ovf[i]) begin
            s_next.pol_act[i] = s_reg.pol_pre[i];
         end
         // high from overflow until the active duty match
         s_next.raw[i] = ch_cnt[i] < s_reg.duty_act[i];
         cmp_hit[i] = (s_reg.cnt1 == s_reg.duty_act[i])
            && (s_reg.duty_act[i] != 12'h000)
            && (!s_reg.dual || i < 2);
      end

      // dead time setting buffered until counter one overflows
      if (ovf1) begin
         s_next.dt_act = s_reg.dt_pre;
      end

      // cycles since last edge of the raw channel zero waveform
      if (s_next.raw[0] != s_reg.raw[0]) begin
         s_next.dcnt = 7'h00;
      end else if (s_reg.dcnt != DT_SAT) begin
         s_next.dcnt = s_reg.dcnt + 7'h01;
      end

      wave = s_reg.raw;
      dt_on = s_reg.dt_act[DT_EN_BIT] && (s_reg.dt_act[DT_W-1:0] != 7'h00);
      if (dt_on) begin
         // zero rises late after overflow, one rises late after match
         wave[0] = s_reg.raw[0] && (s_reg.dcnt >= s_reg.dt_act[DT_W-1:0]);
         wave[1] = !s_reg.raw[0] && (s_reg.dcnt >= s_reg.dt_act[DT_W-1:0]);
      end else if (s_reg.dt_act[DT_EN_BIT]) begin
         wave[1:0] = 2'b00;
      end

      // pin selection
      for (int i = 0; i < CH_N; i++) begin
         if (s_reg.brk_act) begin
            s_next.pins[i] = s_reg.brk_pat[i];
         end else if (s_reg.oe[i]) begin
            s_next.pins[i] = wave[i] ^ s_reg.pol_act[i];
         end else begin
            s_next.pins[i] = s_reg.port[i];
         end
      end

      // read data captured in the setup phase
      case (apb_req.paddr)
         OFS_CTRL: begin
            rdata[CTRL_DUAL] = s_reg.dual;
            rdata[CTRL_TRANSFER_BIT_ONE] = s_reg.transfer_bit_one;
            rdata[CTRL_TRANSFER_BIT_TWO] = s_reg.transfer_bit_two;
            rdata[CTRL_COMPARE_IRQ_ENABLE] = s_reg.compare_irq_enable;
         end
         OFS_RELOAD_ONE: begin
            rdata[CNT_W-1:0] = s_reg.rld1;
         end
         OFS_RELOAD_TWO: begin
            rdata[CNT_W-1:0] = s_reg.rld2;
         end
         OFS_OUT_CTRL: begin
            rdata[3:0] = s_reg.oe;
         end
         OFS_DEAD_TIME: begin
            rdata[7:0] = s_reg.dt_pre;
         end
         OFS_SHUTDOWN: begin
            rdata[SD_ACTIVE] = s_reg.brk_act;
            rdata[SD_PIN_EN] = s_reg.brk_pen;
            rdata[3:0] = s_reg.brk_pat;
         end
         OFS_COUNT_ONE: begin
            rdata[CNT_W-1:0] = s_reg.cnt1;
         end
         OFS_COUNT_TWO: begin
            rdata[CNT_W-1:0] = s_reg.cnt2;
         end
         OFS_PORT: begin
            rdata[3:0] = s_reg.port;
         end
         default: begin
            for (int i = 0; i < CH_N; i++) begin
               if (apb_req.paddr == OFS_CSR0 + 8'(i * 4)) begin
                  rdata[CSR_POL] = s_reg.pol_pre[i];
                  rdata[CSR_FLAG] = s_reg.flag[i];
               end
               if (apb_req.paddr == OFS_DUTY0 + 8'(i * 4)) begin
                  rdata[CNT_W-1:0] = s_reg.duty_pre[i];
               end
            end
         end
      endcase
      if (rd_setup) begin
         s_next.prdata = rdata;
      end

      // flag clear on status read, only what was shown; new hit wins
      for (int i = 0; i < CH_N; i++) begin
         if (rd_acc && apb_req.paddr == OFS_CSR0 + 8'(i * 4)) begin
            clr[i] = s_reg.prdata[CSR_FLAG];
         end
         s_next.flag[i] = (s_reg.flag[i] & ~clr[i]) | cmp_hit[i];
      end

      // register writes
      if (wr_acc) begin
         case (apb_req.paddr)
            OFS_CTRL: begin
               s_next.dual = apb_req.pwdata[CTRL_DUAL];
               s_next.transfer_bit_one = apb_req.pwdata[CTRL_TRANSFER_BIT_ONE];
               s_next.transfer_bit_two = apb_req.pwdata[CTRL_TRANSFER_BIT_TWO];
               s_next.compare_irq_enable = apb_req.pwdata[CTRL_COMPARE_IRQ_ENABLE];
            end
            OFS_RELOAD_ONE: begin
               s_next.rld1 = apb_req.pwdata[CNT_W-1:0];
            end
            OFS_RELOAD_TWO: begin
               s_next.rld2 = apb_req.pwdata[CNT_W-1:0];
            end
            OFS_OUT_CTRL: begin
               s_next.oe = apb_req.pwdata[3:0];
            end
            OFS_DEAD_TIME: begin
               s_next.dt_pre = apb_req.pwdata[7:0];
            end
            OFS_SHUTDOWN: begin
               s_next.brk_act = apb_req.pwdata[SD_ACTIVE];
               s_next.brk_pen = apb_req.pwdata[SD_PIN_EN];
               s_next.brk_pat = apb_req.pwdata[3:0];
            end
            OFS_PORT: begin
               s_next.port = apb_req.pwdata[3:0];
            end
            default: begin
               for (int i = 0; i < CH_N; i++) begin
                  if (apb_req.paddr == OFS_CSR0 + 8'(i * 4)) begin
                     s_next.pol_pre[i] = apb_req.pwdata[CSR_POL];
                  end
                  if (apb_req.paddr == OFS_DUTY0 + 8'(i * 4)) begin
                     s_next.duty_pre[i] = apb_req.pwdata[CNT_W-1:0];
                  end
               end
            end
         endcase
      end

      // shutdown input sets the active bit over any software clear
      if (s_reg.brk_pen && !shutdown_n) begin
         s_next.brk_act = 1'b1;
      end
      if (s_next.brk_act) begin
         s_next.cnt1 = 12'h000;
         s_next.cnt2 = 12'h000;
         s_next.rld1 = 12'h000;
         s_next.rld2 = 12'h000;
         s_next.duty_pre = '0;
         s_next.duty_act = '0;
         s_next.oe = 4'h0;
      end

      s_next.cmp_req = s_reg.compare_irq_enable && (s_next.flag != 4'h0);
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
         s_reg.transfer_bit_one <= TRAN_RESET;
         s_reg.transfer_bit_two <= TRAN_RESET;
         s_reg.port <= PORT_RESET;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : dual_reload_pwm_timer

// [dual_reload_pwm_timer_pkg.sv]
// Contract
// - dual mode gives outputs two, three counter two
// - counters run from reload up to 4095
// - counters start from zero after reset
// - duty preload copied to active at overflow
// - transfer bit one/two gate counter one/two channels
// - output high at overflow, low at match
// - polarity inverts after waveform, synced to overflow only while transfer bit set
// - per-channel enable selects waveform or port
// - dead time complements outputs zero and one
// - dead-time setting takes effect after overflow
// - enable with zero count holds reset state
// - dead-time edges follow match and overflow
// - inverted polarity gives overlapping outputs
// - shutdown input active low, needs pin enable
// - low input or software sets shutdown active
// - shutdown pattern drives pins after inverters
// - shutdown clears counters, reloads, duties, enables
// - clearing shutdown hands pins to port register
// - counter one match sets compare flag, request
// - compare uses counter one, channels by mode
// - compare only for non-zero active duty
// - overflow loads reload value into counter
// - reading channel status clears its flag
package dual_reload_pwm_timer_pkg;
   localparam int CNT_W = 12;
   localparam int CH_N = 4;
   localparam int DT_W = 7;
   localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
   localparam logic [DT_W-1:0] DT_SAT = 7'h7F;

   // byte offsets of the register map
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RELOAD_ONE = 8'h04;
   localparam logic [7:0] OFS_RELOAD_TWO = 8'h08;
   localparam logic [7:0] OFS_OUT_CTRL = 8'h0C;
   localparam logic [7:0] OFS_DEAD_TIME = 8'h10;
   localparam logic [7:0] OFS_SHUTDOWN = 8'h14;
   localparam logic [7:0] OFS_CSR0 = 8'h18;
   localparam logic [7:0] OFS_DUTY0 = 8'h28;
   localparam logic [7:0] OFS_COUNT_ONE = 8'h38;
   localparam logic [7:0] OFS_COUNT_TWO = 8'h3C;
   localparam logic [7:0] OFS_PORT = 8'h40;
   localparam logic [7:0] OFS_STEP = 8'h04;

   // control register fields
   localparam int CTRL_DUAL = 0;
   localparam int CTRL_TRANSFER_BIT_ONE = 1;
   localparam int CTRL_TRANSFER_BIT_TWO = 2;
   localparam int CTRL_COMPARE_IRQ_ENABLE = 3;
   // dead time register fields
   localparam int DT_EN_BIT = 7;
   // shutdown register fields
   localparam int SD_ACTIVE = 5;
   localparam int SD_PIN_EN = 4;
   // channel status fields
   localparam int CSR_POL = 1;
   localparam int CSR_FLAG = 0;

   // reset values
   localparam logic TRAN_RESET = 1'b1;
   localparam logic [3:0] PORT_RESET = 4'h0;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic [CNT_W-1:0] cnt1;
      logic [CNT_W-1:0] cnt2;
      logic [CNT_W-1:0] rld1;
      logic [CNT_W-1:0] rld2;
      logic dual;
      logic transfer_bit_one;
      logic transfer_bit_two;
      logic compare_irq_enable;
      logic [3:0] oe;
      logic [7:0] dt_pre;
      logic [7:0] dt_act;
      logic brk_act;
      logic brk_pen;
      logic [3:0] brk_pat;
      logic [3:0] port;
      logic [3:0] pol_pre;
      logic [3:0] pol_act;
      logic [3:0] flag;
      logic [CH_N-1:0][CNT_W-1:0] duty_pre;
      logic [CH_N-1:0][CNT_W-1:0] duty_act;
      logic [3:0] raw;
      logic [DT_W-1:0] dcnt;
      logic [3:0] pins;
      logic cmp_req;
      logic [31:0] prdata;
   } timer_state_t;
endpackage : dual_reload_pwm_timer_pkg

// [pwm_load_model.sv]
`timescale 1ns/1ps
module pwm_load_model (
   // clock and pins
   input wire logic clk_sys,
   input wire logic [3:0] modulated_output,
   // measured figures
   output logic [12:0] high0,
   output logic [12:0] high1,
   output logic [12:0] period0,
   output logic overlap
);
   logic [12:0] h0 = '0;
   logic [12:0] h1 = '0;
   logic [12:0] p0 = '0;
   logic [1:0] last = '0;
   initial begin
      high0 = '0;
      high1 = '0;
      period0 = '0;
      overlap = 1'b0;
   end
   always @(posedge clk_sys) begin
      last <= modulated_output[1:0];
      if (modulated_output[0] && !last[0]) begin
         high0 <= h0;
         period0 <= p0;
         h0 <= 13'h1;
         p0 <= 13'h1;
      end else begin
         h0 <= h0 + 13'(modulated_output[0]);
         p0 <= p0 + 13'h1;
      end
      if (!modulated_output[1] && last[1]) begin
         high1 <= h1;
         h1 <= 13'h0;
      end else begin
         h1 <= h1 + 13'(modulated_output[1]);
      end
      // both half-bridge legs on at once
      if (&modulated_output[1:0]) begin
         overlap <= 1'b1;
      end
   end
endmodule : pwm_load_model

// [dual_reload_pwm_timer_asserts.sv]
`timescale 1ns/1ps
module dual_reload_pwm_timer_asserts
   import dual_reload_pwm_timer_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // apb
   input apb_req_t apb_req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins
   input wire logic shutdown_n,
   input wire logic [3:0] modulated_output,
   input wire logic compare_request
);
   logic pen_h;
   logic compare_irq_enable_h;
   logic [3:0] pat_h;
   logic wr_go;
   assign wr_go = apb_req.psel && apb_req.penable && apb_req.pwrite && pready;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pen_h <= 1'b0;
         compare_irq_enable_h <= 1'b0;
         pat_h <= 4'h0;
      end else if (wr_go && apb_req.paddr == OFS_SHUTDOWN) begin
         pen_h <= apb_req.pwdata[SD_PIN_EN];
         pat_h <= apb_req.pwdata[3:0];
      end else if (wr_go && apb_req.paddr == OFS_CTRL) begin
         compare_irq_enable_h <= apb_req.pwdata[CTRL_COMPARE_IRQ_ENABLE];
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   sequence rd_setup(a);
      apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == a;
   endsequence
   sequence brk_seen;
      pen_h && !shutdown_n;
   endsequence
   property halt_read(a);
      brk_seen ##1 rd_setup(a) |=> prdata == 32'h0;
   endproperty
   chk_pin_pattern: assert property (brk_seen ##1 $stable(pat_h) |=> modulated_output == pat_h)
      else $error("shutdown pattern missing on pins");
   chk_halt_count: assert property (halt_read(OFS_COUNT_ONE))
      else $error("counter not cleared in shutdown");
   chk_halt_reload: assert property (halt_read(OFS_RELOAD_ONE))
      else $error("reload not cleared in shutdown");
   chk_soft_break: assert property (wr_go && apb_req.paddr == OFS_SHUTDOWN &&
      apb_req.pwdata[SD_ACTIVE] |=> ##1 modulated_output == $past(apb_req.pwdata[3:0], 2))
      else $error("software shutdown without pattern");
   chk_req_masked: assert property (!compare_irq_enable_h && !$past(compare_irq_enable_h) |-> !compare_request)
      else $error("compare request while disabled");
   chk_err_unmapped: assert property (apb_req.psel && apb_req.penable &&
      (apb_req.paddr[1:0] != 2'h0 || apb_req.paddr > OFS_PORT) |-> pslverr)
      else $error("unmapped access without error");
   chk_err_phase: assert property (pslverr |-> apb_req.psel && apb_req.penable)
      else $error("error outside access phase");
   chk_rdata_hold: assert property
      (!$past(apb_req.psel && !apb_req.penable && !apb_req.pwrite) |-> $stable(prdata))
      else $error("read data moved without a read");
   chk_ready_high: assert property (pready)
      else $error("wait state inserted");
endmodule : dual_reload_pwm_timer_asserts
bind dual_reload_pwm_timer dual_reload_pwm_timer_asserts chk_u (.clk_sys(clk_sys),
   .rst_b(rst_b), .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .shutdown_n(shutdown_n), .modulated_output(modulated_output),
   .compare_request(compare_request));

// [dual_reload_pwm_timer_tb.sv]
`timescale 1ns/1ps
module dual_reload_pwm_timer_tb;
   import dual_reload_pwm_timer_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic shutdown_n = 1'b1;
   apb_req_t apb_req = '0;
   logic [31:0] prdata;
   logic pready, pslverr, compare_request, err, ovl;
   logic [3:0] modulated_output, acc;
   logic [12:0] high0, high1, period0;
   logic [31:0] rd;
   int bad_count = 0;
   int compares = 0;
   int n;
   always #12.5 clk_sys = ~clk_sys;
   dual_reload_pwm_timer dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .apb_req(apb_req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .shutdown_n(shutdown_n),
      .modulated_output(modulated_output), .compare_request(compare_request));
   pwm_load_model load_u (.clk_sys(clk_sys), .modulated_output(modulated_output),
      .high0(high0), .high1(high1), .period0(period0), .overlap(ovl));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         bad_count++;
      end
      rd = prdata;
      err = pslverr;
      apb_req <= '0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk
   task automatic pulse(input logic [12:0] h, input logic [12:0] p);
      repeat (60) @(posedge clk_sys);
      check(high0, h);
      check(period0, p);
   endtask : pulse
   task automatic pins(input logic [3:0] exp);
      repeat (3) @(posedge clk_sys);
      check(modulated_output, exp);
   endtask : pins
   task automatic tally_and_finish;
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #750000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      rdchk(OFS_COUNT_ONE, 32'h1);
      rdchk(OFS_COUNT_ONE, 32'h4);
      rdchk(OFS_CTRL, 32'h6);
      rdchk(8'h44, 32'h0);
      check(err, 1'b1);
      // pwm period and duty
      wr(OFS_RELOAD_ONE, 32'hFF0);
      wr(OFS_DUTY0, 32'hFF8);
      wr(OFS_OUT_CTRL, 32'h1);
      repeat (4200) @(posedge clk_sys);
      pulse(13'h8, 13'h10);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_DUTY0, 32'hFF4);
      pulse(13'h8, 13'h10);
      wr(OFS_CTRL, 32'h2);
      pulse(13'h4, 13'h10);
      wr(OFS_CSR0, 32'h2);
      pulse(13'hC, 13'h10);
      // dead time on the half bridge
      wr(OFS_CSR0, 32'h0);
      wr(OFS_DUTY0, 32'hFF8);
      wr(OFS_OUT_CTRL, 32'h3);
      wr(OFS_DEAD_TIME, 32'h83);
      pulse(13'h5, 13'h10);
      check(high1, 13'h5);
      check(ovl, 1'b0);
      wr(OFS_DEAD_TIME, 32'h80);
      repeat (40) @(posedge clk_sys);
      acc = 4'h0;
      repeat (20) begin
         @(posedge clk_sys);
         acc |= modulated_output;
      end
      check(acc[1:0], 2'h0);
      // port control and shutdown
      wr(OFS_PORT, 32'hA);
      wr(OFS_OUT_CTRL, 32'h0);
      wr(OFS_DEAD_TIME, 32'h0);
      @(posedge clk_sys);
      shutdown_n <= 1'b0;
      pins(4'hA);
      rdchk(OFS_SHUTDOWN, 32'h0);
      wr(OFS_SHUTDOWN, 32'h15);
      pins(4'h5);
      rdchk(OFS_SHUTDOWN, 32'h35);
      rdchk(OFS_RELOAD_ONE, 32'h0);
      rdchk(OFS_OUT_CTRL, 32'h0);
      rdchk(OFS_DUTY0, 32'h0);
      rdchk(OFS_COUNT_ONE, 32'h0);
      @(posedge clk_sys);
      shutdown_n <= 1'b1;
      wr(OFS_SHUTDOWN, 32'h10);
      pins(4'hA);
      wr(OFS_SHUTDOWN, 32'h2C);
      pins(4'hC);
      wr(OFS_SHUTDOWN, 32'h0);
      // output compare on counter one
      wr(OFS_DUTY0, 32'h800);
      wr(OFS_CTRL, 32'hA);
      n = 0;
      while (compare_request !== 1'b1 && n < 9000) begin
         @(posedge clk_sys);
         n++;
      end
      check(compare_request, 1'b1);
      rdchk(OFS_CSR0, 32'h1);
      rdchk(OFS_CSR0, 32'h0);
      rdchk(OFS_CSR0 + OFS_STEP, 32'h0);
      check(compare_request, 1'b0);
      // dual mode: channel two on counter two
      wr(OFS_CTRL, 32'h7);
      wr(OFS_RELOAD_TWO, 32'hFF8);
      wr(OFS_DUTY0 + 8'h08, 32'hFFC);
      wr(OFS_OUT_CTRL, 32'h4);
      repeat (4200) @(posedge clk_sys);
      n = 0;
      repeat (64) begin
         @(posedge clk_sys);
         n += int'(modulated_output[2]);
      end
      check(32'(n), 32'h20);
      rdchk(OFS_CSR0 + 8'h08, 32'h0);
      tally_and_finish();
   end
endmodule : dual_reload_pwm_timer_tb
